// File: dv/adcsr_host.sv
// serial host model driving select and clock
`timescale 1ns/1ns
module adcsr_host (
  output logic cs_n,
  output logic sck,
  input wire logic sdo
);
  // idle deselected, clock high
  initial begin
    cs_n = 1'b1;
    sck = 1'b1;
  end
  // n clock pulses, bits taken on rising clock
  task automatic read(input int n, output logic [15:0] d);
    d = '0;
    sck = 1'b0;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      #63 sck = 1'b1;
      d = {d[14:0], sdo};
      #62 sck = 1'b0;
    end
    #63 cs_n = 1'b1;
    sck = 1'b1;
  endtask
  // status look with clock held high
  task automatic peek(output logic s);
    cs_n = 1'b0;
    #100 s = sdo;
    cs_n = 1'b1;
  endtask
endmodule

// File: dv/adcsr_props.sv
// port checks of the converter control block
`timescale 1ns/1ns
module adcsr_props
  import adcsr_pkg::*;
#(
  parameter int CONV_COUNT = 200,
  parameter int POR_COUNT = 20
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire adcsr_pkg::adcsr_pins_t pins,
  input wire adcsr_pkg::adcsr_sdo_t sdo_pin,
  input wire logic [adcsr_pkg::RES_W-1:0] result,
  input wire logic converting,
  input wire logic por_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_oe_off: assert property (
    pins.cs_n [*4] |-> !sdo_pin.sdo_oe) else $error("sdo driven");
  a_oe_on: assert property (
    (!pins.cs_n && !por_active) [*4] |-> sdo_pin.sdo_oe)
    else $error("sdo not driven");
  a_conv_len: assert property (
    $rose(converting) |-> ##199 converting ##1 !converting)
    else $error("bad conversion length");
  a_result_hold: assert property (
    !converting && !por_active && pins.supply_ok |=> $stable(result))
    else $error("result moved");
  a_busy_flag: assert property (
    converting && sdo_pin.sdo_oe |-> sdo_pin.sdo) else $error("busy low");
  a_por_clear: assert property (
    por_active |-> result == 16'h0000 && !sdo_pin.sdo_oe)
    else $error("por not clear");
  a_por_start: assert property (
    $fell(por_active) |-> converting) else $error("no start");
  a_conv_cause: assert property (
    $rose(converting) |-> $past(por_active) || $past(sdo_pin.sdo_oe, 2))
    else $error("bad start");
endmodule
bind adcsr_core adcsr_props #(.CONV_COUNT(CONV_COUNT),
  .POR_COUNT(POR_COUNT)) u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .pins(pins), .sdo_pin(sdo_pin), .result(result),
  .converting(converting), .por_active(por_active));

// File: dv/tb_top.sv
// self-checking bench of the converter control block
`timescale 1ns/1ns
module tb_top;
  import adcsr_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic supply_ok = 1'b1;
  logic cs_n, sck, sdo_w, s, low_power, converting, por_active;
  logic last = 1'b0;
  logic [15:0] result, d;
  adcsr_core_t core = '{18'sh01234, 18'sh0, 16'h8000};
  adcsr_core_t tv[3];
  adcsr_sdo_t sdo_pin;
  int n_fail = 0;
  int tests_run = 0;
  adcsr_core #(.CONV_COUNT(200), .POR_COUNT(20)) u_dut (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .pins({supply_ok, cs_n, sck}), .core(core),
    .sdo_pin(sdo_pin), .result(result), .low_power(low_power),
    .converting(converting), .por_active(por_active));
  adcsr_host u_host (.cs_n(cs_n), .sck(sck), .sdo(sdo_w));
  // released line shows the inverse of its last value
  always @(posedge ref_clk) if (sdo_pin.sdo_oe) last <= sdo_pin.sdo;
  assign sdo_w = sdo_pin.sdo_oe ? sdo_pin.sdo : ~last;
  initial forever #4 ref_clk = ~ref_clk;
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  function automatic logic [15:0] cal(input adcsr_core_t c);
    logic signed [40:0] v;
    v = ((c.raw - c.offset) * $signed({1'b0, c.gain})) >>> 15;
    return v < 0 ? 16'h0000 : v > 65535 ? 16'hFFFF : v[15:0];
  endfunction
  task automatic wait_idle();
    int i;
    i = 0;
    repeat (5) @(negedge ref_clk);
    while ((converting || por_active) && i < 2000) begin
      @(negedge ref_clk);
      i++;
    end
    // a conversion that never ends counts as a mismatch
    if (i >= 2000) begin
      n_fail++;
      $display("CHECK FAILED idle exp 0 got 1");
    end
  endtask
  // full readouts over plain and clamped codes
  task automatic t_read();
    tv = '{'{-18'sd5, 18'sd0, 16'h8000}, '{18'sh1FFFF, 18'sd0, 16'hFFFF},
      '{18'sh2000, 18'sh1000, 16'h4000}};
    wait_idle();
    u_host.read(16, d);
    chk("word", cal(core), d);
    chk("result", cal(core), result);
    chk("restart", 16'h1, {15'h0, converting});
    foreach (tv[i]) begin
      @(negedge ref_clk);
      core = tv[i];
      wait_idle();
      u_host.read(16, d);
      chk("clamp", cal(tv[i]), d);
    end
    $display("t_read done");
  endtask
  // abort mid-word, then status and low power
  task automatic t_abort();
    wait_idle();
    u_host.read(4, d);
    chk("part", cal(core) >> 12, d);
    repeat (4) @(negedge ref_clk);
    chk("aborted", 16'h1, {15'h0, converting});
    u_host.peek(s);
    chk("busy", 16'h1, {15'h0, s});
    wait_idle();
    u_host.peek(s);
    chk("ready", 16'h0, {15'h0, s});
    repeat (5) @(negedge ref_clk);
    chk("sleep", 16'h1, {15'h0, low_power});
    $display("t_abort done");
  endtask
  // supply loss clears state, recovery starts converting
  task automatic t_por();
    @(negedge ref_clk);
    supply_ok = 1'b0;
    repeat (5) @(negedge ref_clk);
    chk("por", 16'h1, {15'h0, por_active});
    chk("cleared", 16'h0, result);
    supply_ok = 1'b1;
    repeat (30) @(negedge ref_clk);
    chk("start", 16'h1, {15'h0, converting});
    $display("t_por done");
  endtask
  // reset then scenarios
  initial begin
    repeat (5) @(negedge ref_clk);
    sys_rst = 1'b0;
    t_read();
    t_abort();
    t_por();
    stop_test();
  end
  // watchdog
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
endmodule

// File: pkg/adcsr_pkg.sv
// shared constants, types and state layout of the converter control block
package adcsr_pkg;

  // clock and timing figures
  localparam int CLK_PERIOD_NS = 8;
  localparam int CONV_TIME_NS = 33_300_000;
  localparam int CONV_MAX_NS = 42_000_000;
  localparam int POR_TIME_NS = 500_000;
  localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int POR_CYCLES = POR_TIME_NS / CLK_PERIOD_NS;

  // widths
  localparam int RES_W = 16;
  localparam int RAW_W = 18;
  localparam int GAIN_W = 16;
  localparam int GAIN_FRAC = 15;
  localparam int TMR_W = 32;
  localparam int BIT_W = 4;

  // result codes, last bit index and unity gain
  localparam logic [RES_W-1:0] CODE_ZERO = 16'h0000;
  localparam logic [RES_W-1:0] CODE_TOP = 16'hFFFF;
  localparam logic [BIT_W-1:0] LAST_BIT = 4'hF;
  localparam logic [GAIN_W-1:0] GAIN_UNITY = 16'h8000;

  // operating states, one-hot
  typedef enum logic [3:0] {
    ST_POR = 4'h1,
    ST_CONV = 4'h2,
    ST_SLEEP = 4'h4,
    ST_DATA = 4'h8
  } adcsr_fsm_t;

  // pin inputs from outside the clock domain
  typedef struct packed {
    logic supply_ok;
    logic cs_n;
    logic sck;
  } adcsr_pins_t;

  // serial output pin
  typedef struct packed {
    logic sdo;
    logic sdo_oe;
  } adcsr_sdo_t;

  // calibration and modulator data from the analog core
  typedef struct packed {
    logic signed [RAW_W-1:0] raw;
    logic signed [RAW_W-1:0] offset;
    logic [GAIN_W-1:0] gain;
  } adcsr_core_t;

  // whole module state
  typedef struct packed {
    adcsr_fsm_t fsm;
    logic [TMR_W-1:0] timer;
    logic [TMR_W-1:0] por_cnt;
    logic [RES_W-1:0] result;
    logic [RES_W-1:0] shreg;
    logic [BIT_W-1:0] bit_cnt;
    adcsr_pins_t sync1;
    adcsr_pins_t sync2;
    adcsr_pins_t prev;
    adcsr_sdo_t pin;
    logic low_power;
  } adcsr_state_t;

endpackage

// File: rtl/adcsr_core.sv
// control state machine and serial readout of the 16-bit converter
`timescale 1ns/1ns
// What this block does
// - cycle convert, sleep, data output, repeat
// - conversion lasts fixed period, select and clock cannot end
// - leave sleep when chip select and clock low
// - low power while chip select high in sleep
// - result held static throughout sleep
// - top result bit on output at data entry
// - next bit after falling clock; host samples rising
// - shift latest completed result, no latency
// - sixteenth falling clock edge starts new conversion
// - chip select rising aborts readout, new conversion
// - drive output only while chip select low
// - hold reset on low supply, then pulse
// - after reset pulse, start conversion automatically
// - calibrate every conversion without changing timing
// - clamp results to zero and top code
// - straight binary sixteen bits, msb first
// - clock high, select low: output shows busy
module adcsr_core
  import adcsr_pkg::*;
#(
  parameter int CONV_COUNT = adcsr_pkg::CONV_CYCLES,
  parameter int POR_COUNT = adcsr_pkg::POR_CYCLES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire adcsr_pkg::adcsr_pins_t pins,
  input wire adcsr_pkg::adcsr_core_t core,
  output adcsr_pkg::adcsr_sdo_t sdo_pin,
  output logic [adcsr_pkg::RES_W-1:0] result,
  output logic low_power,
  output logic converting,
  output logic por_active
);
  import adcsr_pkg::*;

  localparam logic [TMR_W-1:0] CONV_LAST = TMR_W'(CONV_COUNT - 1);
  localparam logic [TMR_W-1:0] POR_LAST = TMR_W'(POR_COUNT - 1);
  localparam int DIFF_W = RAW_W + 1;
  localparam int PROD_W = DIFF_W + GAIN_W + 1;

  // reset image: registers cleared except the chip-select bits of sync1, sync2 and prev, which load high; waiting in power-on reset
  localparam adcsr_state_t RESET_STATE = '{
    fsm: ST_POR,
    timer: '0,
    por_cnt: '0,
    result: CODE_ZERO,
    shreg: CODE_ZERO,
    bit_cnt: '0,
    sync1: '{supply_ok: 1'b0, cs_n: 1'b1, sck: 1'b0},
    sync2: '{supply_ok: 1'b0, cs_n: 1'b1, sck: 1'b0},
    prev: '{supply_ok: 1'b0, cs_n: 1'b1, sck: 1'b0},
    pin: '{sdo: 1'b0, sdo_oe: 1'b0},
    low_power: 1'b0
  };

  adcsr_state_t state;
  adcsr_state_t next_state;
  logic sck_fall;
  logic cs_rise;
  logic cs_low;
  logic sck_high;
  logic [RES_W-1:0] cal_code;

  // offset and full-scale correction, then clamp to the code range
  function automatic logic [RES_W-1:0] calibrate(input adcsr_core_t c);
    logic signed [DIFF_W-1:0] diff;
    logic signed [PROD_W-1:0] prod;
    logic signed [PROD_W-1:0] scaled;
    diff = DIFF_W'(c.raw) - DIFF_W'(c.offset);
    prod = PROD_W'(diff) * $signed({1'b0, c.gain});
    scaled = prod >>> GAIN_FRAC;
    if (scaled < 0) begin
      calibrate = CODE_ZERO;
    end else if (scaled > $signed({{(PROD_W-RES_W){1'b0}}, CODE_TOP})) begin
      calibrate = CODE_TOP;
    end else begin
      calibrate = scaled[RES_W-1:0];
    end
  endfunction

  // edges and levels of the synchronised pins
  assign sck_fall = state.prev.sck & ~state.sync2.sck;
  assign cs_rise = ~state.prev.cs_n & state.sync2.cs_n;
  assign cs_low = ~state.sync2.cs_n;
  assign sck_high = state.sync2.sck;
  assign cal_code = calibrate(core);

  // next-state logic
  always_comb begin
    next_state = state;
    // two-flop synchronisers, then one stage kept for edge finding
    next_state.sync1 = pins;
    next_state.sync2 = state.sync1;
    next_state.prev = state.sync2;
    next_state.low_power = 1'b0;

    case (state.fsm)
      ST_POR: begin
        next_state.timer = '0;
        next_state.result = CODE_ZERO;
        next_state.shreg = CODE_ZERO;
        next_state.bit_cnt = '0;
        if (state.sync2.supply_ok) begin
          if (state.por_cnt == POR_LAST) begin
            next_state.fsm = ST_CONV;
            next_state.por_cnt = '0;
          end else begin
            next_state.por_cnt = state.por_cnt + 1'b1;
          end
        end else begin
          next_state.por_cnt = '0;
        end
      end
      ST_CONV: begin
        // only the timer or a brown-out ends a conversion; select and clock are ignored here
        if (state.timer == CONV_LAST) begin
          next_state.fsm = ST_SLEEP;
          next_state.result = cal_code;
          next_state.timer = '0;
        end else begin
          next_state.timer = state.timer + 1'b1;
        end
      end
      ST_SLEEP: begin
        next_state.low_power = ~cs_low;
        if (cs_low && !sck_high) begin
          next_state.fsm = ST_DATA;
          next_state.shreg = state.result;
          next_state.bit_cnt = '0;
        end
      end
      ST_DATA: begin
        if (cs_rise) begin
          next_state.fsm = ST_CONV;
          next_state.timer = '0;
          next_state.shreg = CODE_ZERO;
          next_state.bit_cnt = '0;
        end else if (sck_fall) begin
          if (state.bit_cnt == LAST_BIT) begin
            next_state.fsm = ST_CONV;
            next_state.timer = '0;
            next_state.bit_cnt = '0;
          end else begin
            next_state.shreg = {state.shreg[RES_W-2:0], 1'b0};
            next_state.bit_cnt = state.bit_cnt + 1'b1;
          end
        end
      end
      default: begin
        next_state.fsm = ST_POR;
      end
    endcase

    // brown-out forces power-on reset from any state
    if (!state.sync2.supply_ok) begin
      next_state.fsm = ST_POR;
      next_state.por_cnt = '0;
      // clear result on entry so nothing stale shows during reset
      next_state.result = CODE_ZERO;
      next_state.shreg = CODE_ZERO;
      next_state.bit_cnt = '0;
      next_state.timer = '0;
    end

    // serial output value follows the upcoming state
    case (next_state.fsm)
      ST_CONV: next_state.pin.sdo = 1'b1;
      ST_SLEEP: next_state.pin.sdo = 1'b0;
      ST_DATA: next_state.pin.sdo = next_state.shreg[RES_W-1];
      default: next_state.pin.sdo = 1'b0;
    endcase
    next_state.pin.sdo_oe = ~next_state.sync2.cs_n &
                            (next_state.fsm != ST_POR);
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= RESET_STATE;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from the state register
  assign sdo_pin = state.pin;
  assign result = state.result;
  assign low_power = state.low_power;
  assign converting = (state.fsm == ST_CONV);
  assign por_active = (state.fsm == ST_POR);

endmodule
